// file: fault_status_defs.svh
// offsets, field masks, reset values and sizes of the fault-status block
`ifndef FAULT_STATUS_DEFS_SVH
`define FAULT_STATUS_DEFS_SVH

// ----------------------------------------------------------------------------
// parameter addresses, as seen by the fieldbus master
// ----------------------------------------------------------------------------
`define LAST_STOP_OFS      16'h1c0a
`define LATCHED_SIG_OFS    16'h1c10
`define LAST_CLASS0_OFS    16'h1c12
`define HIST_CODE_OFS      16'h3c02
`define HIST_CLASS_OFS     16'h3c04
`define HIST_TIME_OFS      16'h3c06
`define HIST_QUAL_OFS      16'h3c08
`define HIST_AMPCYC_OFS    16'h3c0a
`define HIST_AMPTIME_OFS   16'h3c0c
`define HIST_UDC_OFS       16'h3c0e
`define HIST_VEL_OFS       16'h3c10
`define HIST_CURRENT_OFS   16'h3c12
`define HIST_TEMPPA_OFS    16'h3c14
`define HIST_TEMPDEV_OFS   16'h3c16
`define HIST_POWERON_OFS   16'h3b04

// ----------------------------------------------------------------------------
// latched monitor word: implemented bits 0-4, 6-10, 12, 14-23, 29-31
// ----------------------------------------------------------------------------
`define LATCHED_MASK       32'he0ffd7df
`define MON_MOTION_MASK    32'h0000001f // groups below together make up the implemented set
`define MON_LINK_MASK      32'h000017c0
`define MON_SUPPLY_MASK    32'h0001c000
`define MON_MOTOR_MASK     32'h000e0000
`define MON_LIMIT_MASK     32'h00f00000
`define MON_SYSTEM_MASK    32'he0000000
`define LATCHED_RESET      32'h00000000
`define CODE_RESET         16'h0000
`define CODE_NONE          16'h0000

// ----------------------------------------------------------------------------
// history sizing
// ----------------------------------------------------------------------------
`define HIST_DEPTH         4'ha
`define HIST_LAST_IDX      4'h9

`endif

// file: fault_status_pkg.sv
// types shared by the fault-status block and its history store
package fault_status_pkg;

  // one history entry, captured at the moment an error is detected
  typedef struct packed {
    logic [2:0]  errClass;
    logic [15:0] errCode;
    logic [15:0] motorCurrent;
    logic [31:0] powerOnCount;
    logic [15:0] qualifier;
    logic [15:0] tempDevice;
    logic [15:0] tempPowerStage;
    logic [31:0] detectTime;
    logic [15:0] dcBusVoltage;
    logic [15:0] velocity;
    logic [15:0] enableCycles;
    logic [15:0] enableTime;
  } hist_entry_t;

endpackage

// file: error_history_store.sv
// ten-entry retained error history ring, read back oldest first for sequential readout
`include "fault_status_defs.svh"

module error_history_store (
  // clock and retained-memory initialisation
  input  wire logic                          mclk,
  input  wire logic                          nvClear,
  // capture side
  input  wire logic                          wrEn,
  input  wire fault_status_pkg::hist_entry_t wrEntry,
  // read side, by position counted from the oldest entry
  input  wire logic [3:0]                    rdPos,
  output fault_status_pkg::hist_entry_t      rdEntry,
  output logic [3:0]                         count
);
  import fault_status_pkg::*;

  // ----------------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------------
  // memory and its pointers are not touched by rst: they model the retained store
  hist_entry_t mem [0:9];
  logic [3:0]  wrIdx;
  logic [3:0]  oldest;
  logic [4:0]  sum;
  logic [3:0]  rdIdx;

  // write slot and fill level; only the one-time initialisation clears them
  always_ff @(posedge mclk) begin
    if (nvClear) begin
      wrIdx <= 4'h0;
      count <= 4'h0;
    end else if (wrEn) begin
      wrIdx <= (wrIdx == `HIST_LAST_IDX) ? 4'h0 : wrIdx + 4'h1;
      if (count != `HIST_DEPTH) begin
        count <= count + 4'h1;
      end
    end
  end

  // entries are written into the slot after the newest, overwriting the oldest
  always_ff @(posedge mclk) begin
    if (wrEn && !nvClear) begin
      mem[wrIdx] <= wrEntry;
    end
  end

  // ----------------------------------------------------------------------------
  // read addressing
  // ----------------------------------------------------------------------------
  // once full the oldest sits at the write slot, before that at slot zero
  always_comb begin
    oldest = (count == `HIST_DEPTH) ? wrIdx : 4'h0;
    sum    = {1'b0, oldest} + {1'b0, rdPos};
    rdIdx  = (sum >= {1'b0, `HIST_DEPTH}) ? 4'(sum - {1'b0, `HIST_DEPTH}) : sum[3:0];
  end

  // beyond the fill level an all-zero entry is returned so the code reads zero
  assign rdEntry = (rdPos < count) ? mem[rdIdx] : '0;

endmodule

// file: drive_fault_status_memory.sv
// fault-status word, last error codes and sequential error history readout
`include "fault_status_defs.svh"

module drive_fault_status_memory (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        nvClear,
  // monitoring conditions and fault reset
  input  wire logic [31:0] monitorEvents,
  input  wire logic        faultReset,
  // detected error, with the live operating values to snapshot
  input  wire logic        errValid,
  input  wire logic [2:0]  errClass,
  input  wire logic [15:0] errCode,
  input  wire logic [15:0] errQualifier,
  input  wire logic [15:0] motorCurrent,
  input  wire logic [31:0] powerOnCount,
  input  wire logic [15:0] tempDevice,
  input  wire logic [15:0] tempPowerStage,
  input  wire logic [31:0] hoursCounter,
  input  wire logic [15:0] dcBusVoltage,
  input  wire logic [15:0] velocity,
  input  wire logic [15:0] enableCycles,
  input  wire logic [15:0] enableTime,
  // parameter read port
  input  wire logic        paramRead,
  input  wire logic [15:0] paramAddr,
  input  wire logic        historyPointerReset,
  output logic             paramValid,
  output logic [31:0]      paramData,
  output logic             paramUnmapped
);
  import fault_status_pkg::*;

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  logic [31:0] latchedMonitorSignals;
  logic [15:0] lastClass0ErrorCode;
  logic [15:0] lastStopErrorCode;
  logic [3:0]  rdPtr;
  hist_entry_t holdBuf;
  hist_entry_t snapEntry;
  hist_entry_t rdEntry;
  logic [3:0]  histCount;
  logic        codeRead;
  logic        isStop;
  logic [31:0] next_paramData;
  logic        next_paramUnmapped;

  assign codeRead = paramRead && (paramAddr == `HIST_CODE_OFS);
  assign isStop   = (errClass >= 3'h1) && (errClass <= 3'h4);

  // ----------------------------------------------------------------------------
  // latched monitoring word
  // ----------------------------------------------------------------------------
  // a condition active in the clearing cycle survives the fault reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      latchedMonitorSignals <= `LATCHED_RESET;
    end else if (faultReset) begin
      latchedMonitorSignals <= monitorEvents & `LATCHED_MASK;
    end else begin
      // sticky OR; the mask keeps reserved positions at zero
      latchedMonitorSignals <= latchedMonitorSignals | (monitorEvents & `LATCHED_MASK);
    end
  end

  // ----------------------------------------------------------------------------
  // most recent error codes
  // ----------------------------------------------------------------------------
  // a class 0 error in the fault-reset cycle wins over the clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lastClass0ErrorCode <= `CODE_RESET;
    end else if (errValid && errClass == 3'h0) begin
      lastClass0ErrorCode <= errCode;
    end else if (faultReset) begin
      lastClass0ErrorCode <= `CODE_NONE;
    end
  end

  // the stop code is informational and is left alone by fault reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lastStopErrorCode <= `CODE_RESET;
    end else if (errValid && isStop) begin
      lastStopErrorCode <= errCode;
    end
  end

  // ----------------------------------------------------------------------------
  // history capture
  // ----------------------------------------------------------------------------
  // the snapshot is built from the live inputs in the detection cycle itself
  always_comb begin
    snapEntry.errClass       = errClass;
    snapEntry.errCode        = errCode;
    snapEntry.motorCurrent   = motorCurrent;
    snapEntry.powerOnCount   = powerOnCount;
    snapEntry.qualifier      = errQualifier;
    snapEntry.tempDevice     = tempDevice;
    snapEntry.tempPowerStage = tempPowerStage;
    snapEntry.detectTime     = hoursCounter;
    snapEntry.dcBusVoltage   = dcBusVoltage;
    snapEntry.velocity       = velocity;
    snapEntry.enableCycles   = enableCycles;
    snapEntry.enableTime     = enableTime;
  end

  error_history_store u_store (
    .mclk    (mclk),
    .nvClear (nvClear),
    .wrEn    (errValid),
    .wrEntry (snapEntry),
    .rdPos   (rdPtr),
    .rdEntry (rdEntry),
    .count   (histCount)
  );

  // ----------------------------------------------------------------------------
  // sequential readout
  // ----------------------------------------------------------------------------
  // pointer reset wins over an advance in the same cycle; it parks at the depth
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdPtr <= 4'h0;
    end else if (historyPointerReset) begin
      rdPtr <= 4'h0;
    end else if (codeRead && rdPtr != `HIST_DEPTH) begin
      rdPtr <= rdPtr + 4'h1;
    end
  end

  // the code read snapshots the whole entry; field reads come from here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      holdBuf <= '0;
    end else if (codeRead) begin
      holdBuf <= rdEntry;
    end
  end

  // ----------------------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------------------
  // fields narrower than 32 bits sit low, upper bits read zero
  always_comb begin
    next_paramData     = 32'h00000000;
    next_paramUnmapped = 1'b0;
    unique case (paramAddr)
      `LATCHED_SIG_OFS:  next_paramData = latchedMonitorSignals;
      `LAST_CLASS0_OFS:  next_paramData = {16'h0000, lastClass0ErrorCode};
      `LAST_STOP_OFS:    next_paramData = {16'h0000, lastStopErrorCode};
      `HIST_CODE_OFS:    next_paramData = {16'h0000, rdEntry.errCode};
      `HIST_CLASS_OFS:   next_paramData = {29'h00000000, holdBuf.errClass};
      `HIST_TIME_OFS:    next_paramData = holdBuf.detectTime;
      `HIST_QUAL_OFS:    next_paramData = {16'h0000, holdBuf.qualifier};
      `HIST_AMPCYC_OFS:  next_paramData = {16'h0000, holdBuf.enableCycles};
      `HIST_AMPTIME_OFS: next_paramData = {16'h0000, holdBuf.enableTime};
      `HIST_UDC_OFS:     next_paramData = {16'h0000, holdBuf.dcBusVoltage};
      `HIST_VEL_OFS:     next_paramData = {16'h0000, holdBuf.velocity};
      `HIST_CURRENT_OFS: next_paramData = {16'h0000, holdBuf.motorCurrent};
      `HIST_TEMPPA_OFS:  next_paramData = {16'h0000, holdBuf.tempPowerStage};
      `HIST_TEMPDEV_OFS: next_paramData = {16'h0000, holdBuf.tempDevice};
      `HIST_POWERON_OFS: next_paramData = holdBuf.powerOnCount;
      default:           next_paramUnmapped = 1'b1;
    endcase
  end

  // answer one cycle after the request; data stays until the next request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      paramValid    <= 1'b0;
      paramData     <= 32'h00000000;
      paramUnmapped <= 1'b0;
    end else begin
      paramValid <= paramRead;
      if (paramRead) begin
        paramData     <= next_paramData;
        paramUnmapped <= next_paramUnmapped;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // assertion helpers
  // ----------------------------------------------------------------------------
  // conditions seen at the last edge; any of them missing from the word is a lost latch
  logic [31:0] prevEvents;
  logic [31:0] missedBits;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prevEvents <= 32'h00000000;
    end else begin
      prevEvents <= monitorEvents & `LATCHED_MASK;
    end
  end

  // must stay zero, also across a fault reset where the word is reloaded
  assign missedBits = prevEvents & ~latchedMonitorSignals;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // latched word
  a_reserved_zero: assert property ((latchedMonitorSignals & ~`LATCHED_MASK) == 32'h00000000)
    else $error("reserved latched bit set");
  a_latch_set: assert property (##1 ((latchedMonitorSignals & $past(monitorEvents) & `LATCHED_MASK)
      == ($past(monitorEvents) & `LATCHED_MASK)))
    else $error("active condition not latched");
  a_latch_sticky: assert property (!faultReset |=> ((latchedMonitorSignals & $past(latchedMonitorSignals))
      == $past(latchedMonitorSignals)))
    else $error("latched bit lost without fault reset");
  a_torque_off_bit: assert property (monitorEvents[4] |=> latchedMonitorSignals[4])
    else $error("torque off bit not latched");
  a_latch_clear: assert property (faultReset
      |=> latchedMonitorSignals == ($past(monitorEvents) & `LATCHED_MASK))
    else $error("fault reset did not reload word");
  a_word_read: assert property (paramRead && paramAddr == `LATCHED_SIG_OFS
      |=> paramData == $past(latchedMonitorSignals))
    else $error("latched word read wrong");

  // each group of monitoring bits on its own
  a_motion_bits: assert property ((missedBits & `MON_MOTION_MASK) == 32'h00000000)
    else $error("motion monitor bit lost");
  a_link_bits: assert property ((missedBits & `MON_LINK_MASK) == 32'h00000000)
    else $error("link monitor bit lost");
  a_supply_bits: assert property ((missedBits & `MON_SUPPLY_MASK) == 32'h00000000)
    else $error("supply monitor bit lost");
  a_motor_bits: assert property ((missedBits & `MON_MOTOR_MASK) == 32'h00000000)
    else $error("motor monitor bit lost");
  a_limit_bits: assert property ((missedBits & `MON_LIMIT_MASK) == 32'h00000000)
    else $error("limit monitor bit lost");
  a_system_bits: assert property ((missedBits & `MON_SYSTEM_MASK) == 32'h00000000)
    else $error("system monitor bit lost");

  // last error codes
  a_class0_update: assert property (errValid && errClass == 3'h0 |=> lastClass0ErrorCode == $past(errCode))
    else $error("class 0 code not updated");
  a_class0_clear: assert property (faultReset && !(errValid && errClass == 3'h0) |=> lastClass0ErrorCode == 16'h0000)
    else $error("class 0 code not cleared");
  a_class0_hold: assert property (!faultReset && !errValid |=> $stable(lastClass0ErrorCode))
    else $error("class 0 code changed without cause");
  a_stop_update: assert property (errValid && isStop |=> lastStopErrorCode == $past(errCode))
    else $error("stop code not updated");
  a_stop_keep: assert property (!(errValid && isStop) |=> $stable(lastStopErrorCode))
    else $error("stop code changed without cause");

  // history store and sequential readout
  a_ptr_advance: assert property (codeRead && !historyPointerReset && rdPtr < 4'ha |=> rdPtr == $past(rdPtr) + 4'h1)
    else $error("read pointer did not advance");
  a_ptr_reset: assert property (historyPointerReset |=> rdPtr == 4'h0)
    else $error("read pointer not reset");
  a_ptr_hold: assert property (!codeRead && !historyPointerReset |=> $stable(rdPtr))
    else $error("read pointer moved without a code read");
  a_ptr_park: assert property (rdPtr <= `HIST_DEPTH)
    else $error("read pointer beyond history depth");
  a_empty_zero: assert property (codeRead && rdPtr >= histCount |=> paramValid && paramData == 32'h00000000)
    else $error("end of history not coded zero");
  a_empty_buffer: assert property (codeRead && rdPtr >= histCount |=> holdBuf == '0)
    else $error("end of history left stale buffer");
  a_code_entry: assert property (codeRead |=> paramData == {16'h0000, $past(rdEntry.errCode)})
    else $error("entry code read wrong");
  a_hold_copy: assert property (codeRead |=> paramData[15:0] == holdBuf.errCode)
    else $error("holding buffer not loaded");
  a_field_buffer: assert property (paramRead && paramAddr == `HIST_POWERON_OFS
      |=> paramData == $past(holdBuf.powerOnCount))
    else $error("field not read from holding buffer");
  a_hist_fill: assert property (errValid && !nvClear && histCount < 4'ha |=> histCount == $past(histCount) + 4'h1)
    else $error("history count not advanced");
  a_hist_saturate: assert property (histCount == `HIST_DEPTH && !nvClear |=> histCount == `HIST_DEPTH)
    else $error("history count passed its depth");

  // answer timing
  a_answer_next: assert property (paramRead |=> paramValid ##1 (paramValid == $past(paramRead)))
    else $error("read not answered next cycle");

  // main scenarios
  c_entry_read: cover property (codeRead && rdPtr < histCount ##1 paramData != 32'h00000000);
  c_hist_full: cover property (histCount == 4'ha && errValid);
  c_fault_reset: cover property (latchedMonitorSignals != 32'h00000000 ##1 faultReset);
  c_end_marker: cover property (codeRead && rdPtr == histCount);
  c_stop_event: cover property (errValid && isStop);

endmodule

// file: fieldbus_master_model.sv
// fieldbus master model issuing single parameter reads
module fieldbus_master_model (
  // clock
  input  wire logic        mclk,
  // requests
  output logic             paramRead,
  output logic [15:0]      paramAddr,
  output logic             historyPointerReset,
  // answers
  input  wire logic        paramValid,
  input  wire logic [31:0] paramData,
  input  wire logic        paramUnmapped
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus from time zero
  initial begin
    paramRead = 1'b0;
    paramAddr = 16'h0000;
    historyPointerReset = 1'b0;
  end
  // rewind the history cursor before a sequential walk
  task automatic rewind();
    @(negedge mclk);
    historyPointerReset = 1'b1;
    @(negedge mclk);
    historyPointerReset = 1'b0;
  endtask
  // the strobe stands one cycle only, so the answer is sampled at the falling edge after the taking edge
  task automatic read(input logic [15:0] addr, output logic [31:0] data, output logic unm, output logic ok);
    @(negedge mclk);
    paramRead = 1'b1;
    paramAddr = addr;
    @(negedge mclk);
    paramRead = 1'b0;
    paramAddr = ~addr; // an idle address never repeats the last one
    ok = paramValid;
    data = paramData;
    unm = paramUnmapped;
  endtask
endmodule

// file: test_drive_fault_status_memory.sv
// self-checking bench for the fault-status block against a queue model
`include "fault_status_defs.svh"

module test_drive_fault_status_memory;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [31:0] entry_t [12];
  localparam logic [31:0] implMask = 32'he0ffd7df;
  logic        mclk, rst, nvClear, faultReset, errValid, paramRead, historyPointerReset, paramValid, paramUnmapped;
  logic [2:0]  errClass;
  logic [15:0] errCode, errQualifier, motorCurrent, tempDevice, tempPowerStage, lastC0, lastStop;
  logic [15:0] dcBusVoltage, velocity, enableCycles, enableTime, paramAddr;
  logic [31:0] monitorEvents, powerOnCount, hoursCounter, paramData, latched;
  logic [15:0] fieldAddr [12];
  entry_t      hist [$];
  int          seed, failures, nChecks, cycles, i;

  drive_fault_status_memory dut (
    .mclk, .rst, .nvClear, .monitorEvents, .faultReset, .errValid, .errClass, .errCode, .errQualifier,
    .motorCurrent, .powerOnCount, .tempDevice, .tempPowerStage, .hoursCounter, .dcBusVoltage, .velocity,
    .enableCycles, .enableTime, .paramRead, .paramAddr, .historyPointerReset, .paramValid, .paramData,
    .paramUnmapped
  );
  fieldbus_master_model master (
    .mclk, .paramRead, .paramAddr, .historyPointerReset, .paramValid, .paramData, .paramUnmapped
  );

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // hang guard, far above the fewer than 800 cycles the sequence needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    if (failures == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic checkData(input logic [31:0] got, input logic [31:0] exp, input logic [15:0] addr);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: data at %h got %h expected %h", $time, addr, got, exp);
    end
  endtask
  task automatic checkFlag(input logic got, input logic exp, input string msg);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask
  // one read through the master, strobe, flag and data all compared
  task automatic expectRead(input logic [15:0] addr, input logic [31:0] exp, input logic unm);
    logic [31:0] d;
    logic        u, ok;
    master.read(addr, d, u, ok);
    checkFlag(ok, 1'b1, "answer strobe");
    checkFlag(u, unm, "unmapped flag");
    checkData(d, exp, addr);
  endtask
  // a condition lasting one cycle must still leave its bit set
  task automatic pulse(input logic [31:0] v);
    @(negedge mclk);
    monitorEvents = v;
    @(negedge mclk);
    monitorEvents = 32'h0;
    latched = latched | (v & implMask);
  endtask
  // conditions live during the fault reset cycle win over the clear
  task automatic faultClear(input logic [31:0] v);
    @(negedge mclk);
    faultReset = 1'b1;
    monitorEvents = v;
    @(negedge mclk);
    faultReset = 1'b0;
    monitorEvents = 32'h0;
    latched = v & implMask;
    lastC0 = 16'h0;
  endtask
  // detect one error; live values move on afterwards, so the entry must hold the snapshot
  task automatic inject(input logic [2:0] cls);
    entry_t e;
    int     k;
    for (k = 0; k < 12; k++) e[k] = $random(seed);
    for (k = 3; k < 11; k++) e[k][31:16] = 16'h0000;
    e[0] = {16'h0000, e[0][15:0] | 16'h0001};
    e[1] = {29'h0, cls};
    @(negedge mclk);
    {errValid, errClass, errCode, hoursCounter, powerOnCount} = {1'b1, cls, e[0][15:0], e[2], e[11]};
    {errQualifier, enableCycles, enableTime, dcBusVoltage} = {e[3][15:0], e[4][15:0], e[5][15:0], e[6][15:0]};
    {velocity, motorCurrent, tempPowerStage, tempDevice} = {e[7][15:0], e[8][15:0], e[9][15:0], e[10][15:0]};
    @(negedge mclk);
    errValid = 1'b0;
    {hoursCounter, powerOnCount, motorCurrent, velocity} = ~{hoursCounter, powerOnCount, motorCurrent, velocity};
    hist.push_back(e);
    if (hist.size() > 10) void'(hist.pop_front());
    if (cls == 3'h0) lastC0 = e[0][15:0];
    else lastStop = e[0][15:0];
  endtask
  // oldest first, code before the fields, then the terminating zero code
  task automatic walk();
    int j, k;
    master.rewind();
    for (j = 0; j < hist.size(); j++)
      for (k = 0; k < 12; k++) expectRead(fieldAddr[k], hist[j][k], 1'b0);
    expectRead(`HIST_CODE_OFS, 32'h0, 1'b0);
  endtask

  // main sequence
  initial begin
    seed = 90;
    {rst, nvClear, faultReset, errValid, errClass, errCode, errQualifier, motorCurrent} = {2'b11, 53'h0};
    {tempDevice, tempPowerStage, dcBusVoltage, velocity, enableCycles, enableTime} = '0;
    {monitorEvents, powerOnCount, hoursCounter, latched, lastC0, lastStop} = '0;
    fieldAddr = '{`HIST_CODE_OFS, `HIST_CLASS_OFS, `HIST_TIME_OFS, `HIST_QUAL_OFS, `HIST_AMPCYC_OFS,
      `HIST_AMPTIME_OFS, `HIST_UDC_OFS, `HIST_VEL_OFS, `HIST_CURRENT_OFS, `HIST_TEMPPA_OFS,
      `HIST_TEMPDEV_OFS, `HIST_POWERON_OFS};
    repeat (12) @(negedge mclk);
    {rst, nvClear} = 2'b00;
    expectRead(`LAST_STOP_OFS, 32'h0, 1'b0);
    expectRead(`LAST_CLASS0_OFS, 32'h0, 1'b0);
    expectRead(16'h1c0e, 32'h0, 1'b1);
    walk();
    // every position in turn, reserved ones included; earlier bits must stay set
    for (i = 0; i < 32; i++) begin
      pulse(32'h1 << i);
      expectRead(`LATCHED_SIG_OFS, latched, 1'b0);
    end
    faultClear(32'h0);
    pulse($random(seed));
    faultClear($random(seed));
    expectRead(`LATCHED_SIG_OFS, latched, 1'b0);
    // thirteen errors cycling through classes 0 to 4, so the history wraps
    for (i = 0; i < 13; i++) begin
      inject(3'(i % 5));
      expectRead(`LAST_CLASS0_OFS, {16'h0, lastC0}, 1'b0);
      expectRead(`LAST_STOP_OFS, {16'h0, lastStop}, 1'b0);
    end
    walk();
    faultClear(32'h0);
    expectRead(`LAST_CLASS0_OFS, 32'h0, 1'b0);
    expectRead(`LAST_STOP_OFS, {16'h0, lastStop}, 1'b0);
    // a second reset clears codes and word but the retained history stays
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    {latched, lastC0, lastStop} = '0;
    expectRead(`LATCHED_SIG_OFS, 32'h0, 1'b0);
    expectRead(`LAST_CLASS0_OFS, 32'h0, 1'b0);
    expectRead(`LAST_STOP_OFS, 32'h0, 1'b0);
    walk();
    summarize();
  end
endmodule
